// *** hdl/dds_ctrl_pkg.sv ***
// Overview of operation
// - Bit 28 of the control word drives the comparator power-down line.
// - Loading bit 27 with 1 halts the block until the next master reset.
// - Bit 26 powers down the auxiliary control DAC alone.
// - Bit 25 powers down the cosine DAC, control DAC and reference together.
// - Bit 24 stops the digital clocks while the multiplier keeps running.
// - Bit 22 selects high oscillator gain and resets to 1.
// - Bit 21 resets to 1 and bypasses and powers down the multiplier loop.
// - Bits 20:16 set the multiplier factor, legal from 4 to 20 inclusive.
// - Writing 1 to bit 15 gives one clear pulse to accumulator 1, then 0.
// - The same update clears bit 15 in the staging buffer; the pulse works in every mode.
// - While bit 14 is 1 both accumulators are held at zero.
// - Bit 13 runs a repeating triangular sweep between the two frequencies in ramped frequency-shift mode.
// - Ramped frequency-shift mode is code 0x2 of the three-bit mode field.
// - The control word sits at byte addresses 1D to 20 hex.
package dds_ctrl_pkg;

  // ---------------------------------------------------------------
  // byte addresses, most significant byte first
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_CW_B3 = 6'h1D;
  localparam logic [5:0] ADDR_CW_B2 = 6'h1E;
  localparam logic [5:0] ADDR_CW_B1 = 6'h1F;
  localparam logic [5:0] ADDR_CW_B0 = 6'h20;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CW_CMP_PD = 28;
  localparam int CW_HALT = 27;
  localparam int CW_CDAC_PD = 26;
  localparam int CW_FULL_PD = 25;
  localparam int CW_DIG_PD = 24;
  localparam int CW_PLL_RANGE = 22;
  localparam int CW_PLL_BYPASS = 21;
  localparam int CW_MULT_LSB = 16;
  localparam int CW_ACC1_ONESHOT = 15;
  localparam int CW_ACC_HOLD = 14;
  localparam int CW_TRIANGLE = 13;
  localparam int CW_MODE_LSB = 9;

  // ---------------------------------------------------------------
  // reset value, readable bits and codes
  // ---------------------------------------------------------------
  localparam logic [31:0] CW_RESET = 32'h0060_0000;
  // open, reserved and self-clearing bits read as zero
  localparam logic [31:0] CW_READ_MASK = 32'h1F7F_6F73;
  localparam logic [2:0] MODE_RAMPED_FSK = 3'h2;
  localparam logic [4:0] MULT_MIN = 5'h04;
  localparam logic [4:0] MULT_MAX = 5'h14;

  typedef enum logic {SWEEP_UP, SWEEP_DOWN} sweep_state_type;

  // byte lane decode: {hit, lane}, lane 3 holds bits 31:24
  function automatic logic [2:0] lane_decode(input logic [5:0] a);
    case (a)
      ADDR_CW_B3: return 3'h7;
      ADDR_CW_B2: return 3'h6;
      ADDR_CW_B1: return 3'h5;
      ADDR_CW_B0: return 3'h4;
      default: return 3'h0;
    endcase
  endfunction

  function automatic logic mult_in_range(input logic [4:0] m);
    return (m >= MULT_MIN) && (m <= MULT_MAX);
  endfunction

endpackage

// *** hdl/control_io_bank.sv ***
`timescale 1ns/1ns
module control_io_bank
  import dds_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic update,
  input wire logic halted,
  output logic [31:0] buf_word
);

  logic [31:0] buf_q;
  logic [31:0] buf_d;
  logic [2:0] lane;

  // ---------------------------------------------------------------
  // staging bytes, moved to the live word on update
  // ---------------------------------------------------------------
  always_comb begin
    buf_d = buf_q;
    lane = lane_decode(wr_addr);
    if (update && !halted) begin
      buf_d[CW_ACC1_ONESHOT] = 1'b0;
    end
    // a write in the update cycle wins over the auto clear
    if (wr_en && !halted && lane[2]) begin
      buf_d[lane[1:0]*8 +: 8] = wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      buf_q <= CW_RESET;
    end else begin
      buf_q <= buf_d;
    end
  end

  assign buf_word = buf_q;

endmodule

// *** hdl/sweep_direction.sv ***
`timescale 1ns/1ns
module sweep_direction
  import dds_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic enable,
  input wire logic at_end,
  input wire logic at_start,
  output logic sweep_down
);

  sweep_state_type state_q;
  sweep_state_type state_d;

  // ---------------------------------------------------------------
  // turn at each limit; restart upward when disabled
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      SWEEP_UP: begin
        if (enable && at_end) begin
          state_d = SWEEP_DOWN;
        end
      end
      SWEEP_DOWN: begin
        if (!enable || at_start) begin
          state_d = SWEEP_UP;
        end
      end
      default: state_d = SWEEP_UP;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= SWEEP_UP;
    end else begin
      state_q <= state_d;
    end
  end

  assign sweep_down = (state_q == SWEEP_DOWN);

endmodule

// *** hdl/dds_control_word_upper_fields.sv ***
`timescale 1ns/1ns
module dds_control_word_upper_fields
  import dds_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic io_wr_en,
  input wire logic io_rd_en,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wr_data,
  input wire logic io_update,
  input wire logic sweep_at_end,
  input wire logic sweep_at_start,
  output logic [7:0] io_rd_data,
  output logic comparator_pd,
  output logic control_dac_pd,
  output logic cosine_dac_pd,
  output logic reference_pd,
  output logic digital_clk_stop,
  output logic pll_high_gain,
  output logic pll_bypass,
  output logic pll_powerdown,
  output logic [4:0] pll_multiplier,
  output logic mult_range_fault,
  output logic acc1_clear,
  output logic acc2_clear,
  output logic triangle_sweep_en,
  output logic sweep_down,
  output logic mode_fault,
  output logic [2:0] operating_mode,
  output logic device_halted
);

  // ---------------------------------------------------------------
  // staging buffer and live control word
  // ---------------------------------------------------------------
  logic [31:0] buf_word;
  logic [31:0] cw_q;
  logic [31:0] cw_d;
  logic halted_q;
  logic halted_d;
  logic load;

  control_io_bank u_bank (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .wr_en(io_wr_en),
    .wr_addr(io_addr),
    .wr_data(io_wr_data),
    .update(io_update),
    .halted(halted_q),
    .buf_word(buf_word)
  );

  // live word loads on update; a halted block takes nothing
  always_comb begin
    load = io_update && !halted_q;
    cw_d = cw_q;
    if (load) begin
      cw_d = buf_word;
      cw_d[CW_ACC1_ONESHOT] = 1'b0;
    end
    // halt is sticky, only rstn ends it
    halted_d = halted_q || (load && buf_word[CW_HALT]);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cw_q <= CW_RESET;
      halted_q <= 1'b0;
    end else begin
      cw_q <= cw_d;
      halted_q <= halted_d;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [7:0] rd_q;
  logic [7:0] rd_d;
  logic [2:0] rd_lane;
  logic [31:0] rd_word;

  // read decode; unmapped address answers zero
  always_comb begin
    rd_d = rd_q;
    rd_lane = lane_decode(io_addr);
    rd_word = cw_q & CW_READ_MASK;
    if (io_rd_en) begin
      rd_d = rd_lane[2] ? rd_word[rd_lane[1:0]*8 +: 8] : 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
    end
  end

  // ---------------------------------------------------------------
  // analog and clock controls
  // ---------------------------------------------------------------
  logic [13:0] ana_q;
  logic [13:0] ana_d;

  // taken from cw_d so outputs line up with the live word
  always_comb begin
    ana_d = '0;
    ana_d[0] = cw_d[CW_CMP_PD];
    // control DAC off on either bit
    ana_d[1] = cw_d[CW_CDAC_PD] | cw_d[CW_FULL_PD];
    ana_d[2] = cw_d[CW_FULL_PD];
    ana_d[3] = cw_d[CW_FULL_PD];
    ana_d[4] = cw_d[CW_DIG_PD] | halted_d;
    ana_d[5] = cw_d[CW_PLL_RANGE];
    // bypass also powers the loop down
    ana_d[6] = cw_d[CW_PLL_BYPASS];
    ana_d[7] = cw_d[CW_PLL_BYPASS];
    ana_d[12:8] = cw_d[CW_MULT_LSB +: 5];
    // flag an illegal factor while the loop is in use
    ana_d[13] = !cw_d[CW_PLL_BYPASS] &&
      !mult_in_range(cw_d[CW_MULT_LSB +: 5]);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ana_q <= {1'b0, CW_RESET[CW_MULT_LSB +: 5],
        CW_RESET[CW_PLL_BYPASS], CW_RESET[CW_PLL_BYPASS],
        CW_RESET[CW_PLL_RANGE], 5'h00};
    end else begin
      ana_q <= ana_d;
    end
  end

  // ---------------------------------------------------------------
  // accumulator clears and sweep
  // ---------------------------------------------------------------
  logic [5:0] dds_q;
  logic [5:0] dds_d;
  logic pulse;
  logic tri_en;
  logic sweep_dir;

  // pulse from the live load only, any mode; the update clears the buffer copy
  assign pulse = load && buf_word[CW_ACC1_ONESHOT];
  // sweep only in ramped frequency-shift mode
  assign tri_en = cw_q[CW_TRIANGLE] && !halted_q &&
    !cw_q[CW_DIG_PD] &&
    (cw_q[CW_MODE_LSB +: 3] == MODE_RAMPED_FSK);

  // direction turns at each sweep limit
  sweep_direction u_sweep (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .enable(tri_en),
    .at_end(sweep_at_end),
    .at_start(sweep_at_start),
    .sweep_down(sweep_dir)
  );

  always_comb begin
    dds_d = '0;
    // pulse or level hold on accumulator 1
    dds_d[0] = pulse | cw_d[CW_ACC_HOLD] | halted_d;
    dds_d[1] = cw_d[CW_ACC_HOLD] | halted_d;
    dds_d[2] = tri_en;
    dds_d[3] = sweep_dir;
    // host put the triangle bit outside its mode
    dds_d[4] = cw_q[CW_TRIANGLE] &&
      (cw_q[CW_MODE_LSB +: 3] != MODE_RAMPED_FSK);
    dds_d[5] = halted_d;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dds_q <= 6'h00;
    end else begin
      dds_q <= dds_d;
    end
  end

  // ---------------------------------------------------------------
  // output mapping, all from flip-flops
  // ---------------------------------------------------------------
  assign io_rd_data = rd_q;
  assign comparator_pd = ana_q[0];
  assign control_dac_pd = ana_q[1];
  assign cosine_dac_pd = ana_q[2];
  assign reference_pd = ana_q[3];
  assign digital_clk_stop = ana_q[4];
  assign pll_high_gain = ana_q[5];
  assign pll_bypass = ana_q[6];
  assign pll_powerdown = ana_q[7];
  assign pll_multiplier = ana_q[12:8];
  assign mult_range_fault = ana_q[13];
  assign acc1_clear = dds_q[0];
  assign acc2_clear = dds_q[1];
  assign triangle_sweep_en = dds_q[2];
  assign sweep_down = dds_q[3];
  assign mode_fault = dds_q[4];
  assign device_halted = dds_q[5];
  assign operating_mode = cw_q[CW_MODE_LSB +: 3];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence s_halt_load;
    io_update && !halted_q && buf_word[CW_HALT];
  endsequence

  sequence s_oneshot_load;
    io_update && !halted_q && buf_word[CW_ACC1_ONESHOT];
  endsequence

  sequence s_pulse_then_drop;
    acc1_clear && !cw_q[CW_ACC1_ONESHOT];
  endsequence

  chk_comparator_pd: assert property (
    comparator_pd == cw_q[CW_CMP_PD])
    else $error("comparator power-down does not follow bit 28");

  chk_halt_entry: assert property (
    s_halt_load |=> (device_halted && digital_clk_stop) [*3])
    else $error("halt did not take effect and hold");

  chk_halt_sticky: assert property (
    device_halted |=> device_halted && $stable(cw_q))
    else $error("halted block changed state");

  chk_control_dac_pd: assert property (
    control_dac_pd == (cw_q[CW_CDAC_PD] || cw_q[CW_FULL_PD]))
    else $error("control DAC power-down wrong");

  chk_full_dac_pd: assert property (
    cw_q[CW_FULL_PD] |-> cosine_dac_pd && reference_pd &&
      control_dac_pd)
    else $error("full DAC power-down incomplete");

  chk_digital_stop: assert property (
    cw_q[CW_DIG_PD] |-> digital_clk_stop &&
      pll_powerdown == cw_q[CW_PLL_BYPASS])
    else $error("digital power-down touched the loop");

  chk_pll_controls: assert property (
    pll_high_gain == cw_q[CW_PLL_RANGE] &&
      pll_bypass == cw_q[CW_PLL_BYPASS])
    else $error("loop gain or bypass wrong");

  chk_mult_range: assert property (
    mult_range_fault == (!cw_q[CW_PLL_BYPASS] &&
      !mult_in_range(cw_q[CW_MULT_LSB +: 5])))
    else $error("multiplier range flag wrong");

  chk_oneshot_pulse: assert property (
    s_oneshot_load |=> s_pulse_then_drop ##1
      (acc1_clear == (cw_q[CW_ACC_HOLD] || device_halted)))
    else $error("accumulator 1 clear is not one pulse");

  chk_hold_clear: assert property (
    cw_q[CW_ACC_HOLD] |-> acc1_clear && acc2_clear)
    else $error("accumulators not held at zero");

  chk_triangle_mode: assert property (
    triangle_sweep_en |-> $past(cw_q[CW_MODE_LSB +: 3]) ==
      MODE_RAMPED_FSK)
    else $error("sweep running outside ramped mode");

  chk_read_top: assert property (
    io_rd_en && io_addr == ADDR_CW_B3 |=>
      io_rd_data == ($past(cw_q[31:24]) & CW_READ_MASK[31:24]))
    else $error("top byte read wrong");

  chk_bypass_powerdown: assert property (
    pll_bypass == cw_q[CW_PLL_BYPASS] &&
      pll_powerdown == cw_q[CW_PLL_BYPASS])
    else $error("bypass does not power the loop down");

  chk_acc2_hold: assert property (
    acc2_clear == (cw_q[CW_ACC_HOLD] || device_halted))
    else $error("accumulator 2 hold does not follow bit 14");

  // staging must not move once halted, or a reset-free restart could leak
  chk_halt_staging: assert property (
    device_halted |=> $stable(buf_word))
    else $error("halted block took a staged write");

  // turn requests seen by the direction machine while it runs
  sequence s_turn_down;
    tri_en && !sweep_dir && sweep_at_end;
  endsequence

  sequence s_turn_up;
    tri_en && sweep_dir && sweep_at_start;
  endsequence

  chk_sweep_turn_down: assert property (
    s_turn_down |-> ##2 sweep_down)
    else $error("sweep did not turn at the end frequency");

  chk_sweep_turn_up: assert property (
    s_turn_up |-> ##2 !sweep_down)
    else $error("sweep did not turn at the start frequency");

endmodule

// *** tb/host_port_model.sv ***
`timescale 1ns/1ns
module host_port_model
  import dds_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] io_rd_data,
  output logic io_wr_en,
  output logic io_rd_en,
  output logic [5:0] io_addr,
  output logic [7:0] io_wr_data,
  output logic io_update
);
  // ---------------------------------------------------------------
  // host port driver
  // ---------------------------------------------------------------
  // rogue lets a scenario break the host rules on purpose
  logic rogue = 1'b0;

  // idle bus at time zero
  initial begin
    io_wr_en = 1'b0;
    io_rd_en = 1'b0;
    io_update = 1'b0;
    io_addr = 6'h00;
    io_wr_data = 8'h00;
  end

  // released data shows the inverse so stale bytes never look valid
  task automatic release_bus();
    @(posedge clk_sys);
    #5;
    io_wr_en = 1'b0;
    io_rd_en = 1'b0;
    io_update = 1'b0;
    io_wr_data = ~io_wr_data;
  endtask

  task automatic wr_byte(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #5;
    io_wr_en = 1'b1;
    io_addr = a;
    io_wr_data = d;
  endtask

  // bytes go back to back, most significant first
  task automatic write_word(input logic [31:0] w, output logic [31:0] s);
    s = w;
    if (!rogue) begin
      s[27] = 1'b0;
      s[23] = 1'b0;
      if (s[20:16] < MULT_MIN || s[20:16] > MULT_MAX) begin
        s[20:16] = 5'h0C;
      end
      if (s[13]) begin
        s[11:9] = MODE_RAMPED_FSK;
      end
    end
    wr_byte(ADDR_CW_B3, s[31:24]);
    wr_byte(ADDR_CW_B2, s[23:16]);
    wr_byte(ADDR_CW_B1, s[15:8]);
    wr_byte(ADDR_CW_B0, s[7:0]);
    release_bus();
  endtask

  task automatic update();
    @(posedge clk_sys);
    #5;
    io_update = 1'b1;
    release_bus();
  endtask

  // data is taken 5 ns after the edge that samples the strobe
  task automatic rd_byte(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #5;
    io_rd_en = 1'b1;
    io_addr = a;
    release_bus();
    d = io_rd_data;
  endtask
endmodule

// *** tb/dds_control_word_upper_fields_tb_top.sv ***
`timescale 1ns/1ns
module dds_control_word_upper_fields_tb_top
  import dds_ctrl_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn, io_wr_en, io_rd_en, io_update, sweep_at_end, sweep_at_start;
  logic [5:0] io_addr;
  logic [7:0] io_wr_data, io_rd_data;
  logic comparator_pd, control_dac_pd, cosine_dac_pd, reference_pd;
  logic digital_clk_stop, pll_high_gain, pll_bypass, pll_powerdown;
  logic [4:0] pll_multiplier;
  logic mult_range_fault, acc1_clear, acc2_clear, triangle_sweep_en;
  logic sweep_down, mode_fault, device_halted;
  logic [2:0] operating_mode;
  logic [18:0] obs;
  int n_fail = 0;
  int comparisons = 0;

  // ---------------------------------------------------------------
  // clock, instances
  // ---------------------------------------------------------------
  always #25 clk_sys = ~clk_sys;

  dds_control_word_upper_fields uut (.clk_sys(clk_sys), .rstn(rstn),
    .io_wr_en(io_wr_en), .io_rd_en(io_rd_en), .io_addr(io_addr),
    .io_wr_data(io_wr_data), .io_update(io_update),
    .sweep_at_end(sweep_at_end), .sweep_at_start(sweep_at_start),
    .io_rd_data(io_rd_data), .comparator_pd(comparator_pd),
    .control_dac_pd(control_dac_pd), .cosine_dac_pd(cosine_dac_pd),
    .reference_pd(reference_pd), .digital_clk_stop(digital_clk_stop),
    .pll_high_gain(pll_high_gain), .pll_bypass(pll_bypass),
    .pll_powerdown(pll_powerdown), .pll_multiplier(pll_multiplier),
    .mult_range_fault(mult_range_fault), .acc1_clear(acc1_clear),
    .acc2_clear(acc2_clear), .triangle_sweep_en(triangle_sweep_en),
    .sweep_down(sweep_down), .mode_fault(mode_fault),
    .operating_mode(operating_mode), .device_halted(device_halted));

  host_port_model host (.clk_sys(clk_sys), .io_rd_data(io_rd_data),
    .io_wr_en(io_wr_en), .io_rd_en(io_rd_en), .io_addr(io_addr),
    .io_wr_data(io_wr_data), .io_update(io_update));

  // static outputs packed for one compare
  assign obs = {comparator_pd, control_dac_pd, cosine_dac_pd, reference_pd,
    digital_clk_stop, pll_high_gain, pll_bypass, pll_powerdown,
    pll_multiplier, mult_range_fault, acc1_clear, acc2_clear, operating_mode};

  // ---------------------------------------------------------------
  // expectations and checks
  // ---------------------------------------------------------------
  function automatic logic [18:0] expect_out(input logic [31:0] w);
    logic f;
    f = !w[21] && (w[20:16] < 5'h04 || w[20:16] > 5'h14);
    return {w[28], w[26] | w[25], w[25], w[25], w[24], w[22], w[21], w[21],
      w[20:16], f, w[14], w[14], w[11:9]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // static outputs land on the edge that takes the update, triangle_sweep_en and mode_fault one edge after
  task automatic apply(input logic [31:0] w, output logic [31:0] s);
    host.write_word(w, s);
    host.update();
    @(posedge clk_sys);
    #5;
  endtask

  task automatic readback(input logic [31:0] s);
    logic [7:0] d;
    logic [31:0] m;
    m = s & CW_READ_MASK;
    for (int i = 0; i < 4; i++) begin
      host.rd_byte(6'h1D + 6'(i), d);
      chk(d, m[8*(3-i) +: 8]);
    end
  endtask

  // bounded run
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_fail++;
    end_of_test();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] w, s;
    logic [7:0] d;
    rstn = 1'b0;
    sweep_at_end = 1'b0;
    sweep_at_start = 1'b0;
    void'($urandom(32'h6b10));
    repeat (16) @(posedge clk_sys);
    #5;
    rstn = 1'b1;
    chk(obs, expect_out(CW_RESET));
    readback(CW_RESET);
    host.rd_byte(6'h21, d);
    chk(d, 8'h00);
    $display("test reset done");
    // random words, first two at the multiplier bounds
    for (int i = 0; i < 40; i++) begin
      w = $urandom();
      w[15] = 1'b0;
      if (i < 2) begin
        w[21] = 1'b0;
        w[20:16] = (i == 0) ? 5'h04 : 5'h14;
      end
      apply(w, s);
      chk(obs, expect_out(s));
      @(posedge clk_sys);
      #5;
      chk({triangle_sweep_en, mode_fault}, {s[13] && !s[24] &&
        s[11:9] == MODE_RAMPED_FSK, s[13] && s[11:9] != 3'h2});
      readback(s);
    end
    $display("test random words done");
    // one-shot clear in modes 0 to 4
    for (int m = 0; m < 5; m++) begin
      w = $urandom();
      w[15:13] = 3'h4;
      w[11:9] = 3'(m);
      host.write_word(w, s);
      host.update();
      // the pulse stands only in the cycle after the update edge
      chk({acc1_clear, acc2_clear}, 2'h2);
      @(posedge clk_sys);
      #5;
      chk(acc1_clear, 1'b0);
      host.rd_byte(ADDR_CW_B1, d);
      chk(d[7], 1'b0);
      apply(32'h0060_0000, s);
      chk(acc1_clear, 1'b0);
    end
    $display("test one-shot clear done");
    // triangle direction turns at each end
    apply(32'h0060_2400, s);
    @(posedge clk_sys);
    #5;
    chk({triangle_sweep_en, sweep_down}, 2'h2);
    for (int k = 0; k < 2; k++) begin
      sweep_at_end = (k == 0);
      sweep_at_start = (k == 1);
      repeat (3) @(posedge clk_sys);
      #5;
      sweep_at_end = 1'b0;
      sweep_at_start = 1'b0;
      chk(sweep_down, (k == 0));
    end
    $display("test sweep done");
    // illegal factors, then halt
    host.rogue = 1'b1;
    // triangle bit outside ramped mode must not sweep
    apply(32'h0060_2000, s);
    chk({triangle_sweep_en, mode_fault}, 2'h1);
    apply(32'h0003_0000, s);
    chk(mult_range_fault, 1'b1);
    apply(32'h0015_0000, s);
    chk(mult_range_fault, 1'b1);
    apply(32'h0800_0000, s);
    @(posedge clk_sys);
    #5;
    chk({device_halted, digital_clk_stop, acc1_clear, acc2_clear}, 4'hF);
    apply(32'h1000_0000, s);
    chk({comparator_pd, device_halted}, 2'h1);
    host.rd_byte(ADDR_CW_B3, d);
    chk(d, 8'h08);
    rstn = 1'b0;
    repeat (2) @(posedge clk_sys);
    #5;
    rstn = 1'b1;
    host.rogue = 1'b0;
    chk({obs, device_halted}, {expect_out(CW_RESET), 1'b0});
    $display("test halt done");
    end_of_test();
  end
endmodule
